// file: hdl/srb_pkg.sv
// Package: register map, field positions, reset values and timing for the reset/brown-out block
package srb_pkg;
    // APB byte offsets
    localparam logic [7:0] OFF_XINT_EN   = 8'he8;  // extra_interrupt_enable
    localparam logic [7:0] OFF_PWR_CTRL  = 8'h00;  // power_control_reg
    localparam logic [7:0] OFF_FLASH_CFG = 8'h04;  // flash_config_reg
    localparam logic [7:0] OFF_WDOG_CTRL = 8'h08;  // watchdog_control_reg
    localparam logic [7:0] OFF_STAT     = 8'h0c;  // live status, read only
    localparam logic [7:0] OFF_IRQ_STS  = 8'h10;  // sticky events, read only
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;  // write one to clear
    localparam logic [7:0] OFF_IRQ_EN   = 8'h18;  // interrupt enables
    // Field positions
    localparam int BIT_BOD_IE   = 3;  // brownout_irq_enable in extra_interrupt_enable
    localparam int BIT_PWR_ON   = 4;  // power_on_flag in power_control_reg
    localparam int BIT_SW_RST   = 1;  // software_reset_bit in flash_config_reg
    localparam int BIT_WDOG_STS = 2;  // watchdog_status_bit in watchdog_control_reg
    // Event bits of status/clear/enable
    localparam int EV_PIN    = 0;
    localparam int EV_SW_RST = 1;
    localparam int EV_BOR   = 2;
    localparam int EV_BOI   = 3;
    localparam int EV_NUM   = 4;
    // Reset values
    localparam logic [7:0] RST_XINT_EN   = 8'h00;
    localparam logic [7:0] RST_PWR_CTRL  = 8'h00;
    localparam logic [7:0] RST_FLASH_CFG = 8'h00;
    localparam logic [7:0] RST_WDOG_CTRL = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] BOD_VECTOR   = 16'h004b;
    localparam logic [3:0]  BOD_PRIORITY = 4'h2;
    // Timing, in oscillator clocks
    localparam int CLK_PER_MC     = 12;
    localparam int PIN_MIN_MC     = 2;
    localparam int PIN_MIN_CLK    = PIN_MIN_MC * CLK_PER_MC;  // 24 clocks
    localparam int BOD_FILTER_CLK = 4;
    localparam int INIT_CLK       = 16;  // length of internal reset sequence
endpackage : srb_pkg

// file: hdl/srb_filter.sv
// Persistence filter: output rises after the input stays high for COUNT clocks
module srb_filter #(
    parameter int COUNT = 4  // Required consecutive high clocks
) (
    input  wire logic pclk,     // Clock
    input  wire logic presetn,  // Async reset, active low
    input  wire logic din,      // Raw level
    output logic      dout      // Qualified level
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
    logic [CW-1:0] cnt;
    wire           at_last = (cnt == LAST);

    // Count consecutive highs; any low restarts the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt  <= '0;
            dout <= 1'b0;
        end
        else if (!din)
        begin
            cnt  <= '0;
            dout <= 1'b0;
        end
        else
        begin
            if (!at_last)
                cnt <= cnt + CW'(1);
            dout <= at_last;
        end
    end
endmodule // srb_filter

// file: hdl/srb_core.sv
// Reset and brown-out control with APB registers and interrupt
// Functional notes
// R1: After any reset, core restarts fetching at address 0000H.
// R2: External circuit holds reset pin high at least 24 clocks.
// R3: Address latch and program store strobes held weakly high during reset.
// R4: Reset while powered leaves on-chip RAM untouched; power-up contents undefined.
// R5: Completing a reset loads every register with its reset value; here a system reset does not reload irq_sts or irq_en, and irq_sts records the reset event.
// R6: Power-up reset sequence weakly pulls all port pins high first.
// R7: Power-on flag set on power-up, cleared only by software write.
// R8: Software reset only on zero-to-one edge of software-reset bit.
// R9: Software reset keeps software-reset bit, watchdog status bit and RAM.
// R10: Brown-out acts only after low supply persists four clocks.
// R11: Brown-out with interrupt disabled resets processor to 0000H.
// R12: Brown-out with enable bit set raises interrupt to 004BH instead.
// R13: Clearing enable during active brown-out causes a proper reset.
// R14: Reset pin synchronised; reset asserted after 24 consecutive high clocks.
// R15: Brown-out interrupt has priority two and does not wake power-down.
module srb_core #(
    parameter int PIN_CLKS = srb_pkg::PIN_MIN_CLK,    // Pin qualify length
    parameter int BOD_CLKS = srb_pkg::BOD_FILTER_CLK  // Brown-out persistence
) (
    input  wire logic        pclk,           // 25 MHz clock
    input  wire logic        presetn,        // Power-on reset, active low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB direction
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error
    input  wire logic        reset_pin,      // External reset pin, active high
    input  wire logic        brownout_low,   // Supply below brownout_threshold
    input  wire logic        power_down,     // Core in power-down mode
    output logic             core_reset,     // Core/register reset, active high
    output logic [15:0]      fetch_vector,   // Vector for next fetch
    output logic             vector_load,    // Pulse: load fetch_vector
    output logic             strobe_weak_hi, // ALE / program_store_strobe_n weak high
    output logic             port_weak_hi,   // All port pins weak pull-up
    output logic             ram_init_skip,  // High: RAM kept across reset
    output logic             bod_irq_req,    // Brown-out interrupt request
    output logic [3:0]       bod_irq_prio,   // Fixed polling priority
    output logic             irq             // Block interrupt, level
);
    typedef enum logic [3:0] {
        ST_INIT = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_REL  = 4'b0100,
        ST_RUN  = 4'b1000
    } srb_state_e;

    srb_state_e state;
    srb_state_e next_state;
    logic [7:0] xint_en;
    logic [7:0] pwr_ctrl;
    logic [7:0] flash_cfg;
    logic [7:0] wdog_ctrl;
    logic [srb_pkg::EV_NUM-1:0] irq_sts;
    logic [srb_pkg::EV_NUM-1:0] irq_en;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_ok;
    logic       bod_ok;
    logic       sw_rst_q;
    logic       bod_ie_q;
    logic       powered;
    logic [4:0] init_cnt;

    // Brown-out persistence filter, ignores short dips
    // R10: four-clock qualification
    srb_filter #(.COUNT(BOD_CLKS)) u_bod_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (brownout_low),
        .dout    (bod_ok)
    );

    // Reset pin filter fed from the second sync stage only
    // R14: 24 consecutive high clocks
    srb_filter #(.COUNT(PIN_CLKS)) u_pin_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pin_s2),
        .dout    (pin_ok)
    );

    // Two-stage synchroniser on the reset pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end
        else
        begin
            pin_s1 <= reset_pin;
            pin_s2 <= pin_s1;
        end
    end

    // Decode
    wire        bod_ie    = xint_en[srb_pkg::BIT_BOD_IE];
    wire        wr_en     = psel && penable && pwrite;
    wire        sel_xint  = (paddr == srb_pkg::OFF_XINT_EN);
    wire        sel_pwr   = (paddr == srb_pkg::OFF_PWR_CTRL);
    wire        sel_flash = (paddr == srb_pkg::OFF_FLASH_CFG);
    wire        sel_wdog  = (paddr == srb_pkg::OFF_WDOG_CTRL);
    wire        sel_stat  = (paddr == srb_pkg::OFF_STAT);
    wire        sel_sts   = (paddr == srb_pkg::OFF_IRQ_STS);
    wire        sel_clr   = (paddr == srb_pkg::OFF_IRQ_CLR);
    wire        sel_en    = (paddr == srb_pkg::OFF_IRQ_EN);
    wire        mapped    = sel_xint || sel_pwr || sel_flash || sel_wdog
                            || sel_stat || sel_sts || sel_clr || sel_en;
    // R8: rising edge of software-reset bit only
    wire        swr_edge  = flash_cfg[srb_pkg::BIT_SW_RST] && !sw_rst_q;
    // R11: disabled brown-out resets
    wire        bod_rst   = bod_ok && !bod_ie;
    // R13: enable dropped while brown-out active
    wire        bod_ie_fall = bod_ok && bod_ie_q && !bod_ie;
    wire        pin_rst   = pin_ok;
    wire        sys_rst   = pin_rst || swr_edge || bod_rst || bod_ie_fall;
    wire [srb_pkg::EV_NUM-1:0] ev = {bod_ok && bod_ie && !power_down, bod_rst || bod_ie_fall, swr_edge, pin_rst};
    // R9: kept bits apply to a software reset only; other resets clear them
    wire [7:0]  keep_flash = swr_edge ? (8'h01 << srb_pkg::BIT_SW_RST) : 8'h00;
    wire [7:0]  keep_wdog  = swr_edge ? (8'h01 << srb_pkg::BIT_WDOG_STS) : 8'h00;
    wire        in_reset = (state != ST_RUN);

    // Reset sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            ST_INIT: next_state = (init_cnt == 5'(srb_pkg::INIT_CLK - 1)) ? ST_HOLD : ST_INIT;
            ST_HOLD: next_state = sys_rst ? ST_HOLD : ST_REL;
            ST_REL:  next_state = sys_rst ? ST_HOLD : ST_RUN;
            ST_RUN:  next_state = sys_rst ? ST_HOLD : ST_RUN;
            default: next_state = ST_INIT;
        endcase
    end

    // State, init counter and edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state    <= ST_INIT;
            init_cnt <= '0;
            sw_rst_q <= 1'b0;
            bod_ie_q <= 1'b0;
            powered  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            init_cnt <= (state == ST_INIT) ? init_cnt + 5'd1 : '0;
            sw_rst_q <= flash_cfg[srb_pkg::BIT_SW_RST];
            bod_ie_q <= bod_ie;
            // R4: RAM kept once first reset sequence done
            if (state == ST_REL)
                powered <= 1'b1;
        end
    end

    // Registers; a system reset reloads them except the kept bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xint_en   <= srb_pkg::RST_XINT_EN;
            // R7: power-on flag set on power-up
            pwr_ctrl  <= srb_pkg::RST_PWR_CTRL | (8'h01 << srb_pkg::BIT_PWR_ON);
            flash_cfg <= srb_pkg::RST_FLASH_CFG;
            wdog_ctrl <= srb_pkg::RST_WDOG_CTRL;
        end
        else if (sys_rst)
        begin
            // R5: reload reset values
            xint_en   <= srb_pkg::RST_XINT_EN;
            // R7: flag survives warm reset
            pwr_ctrl  <= srb_pkg::RST_PWR_CTRL | (pwr_ctrl & (8'h01 << srb_pkg::BIT_PWR_ON));
            // R9: software reset keeps its own bit and watchdog status
            flash_cfg <= srb_pkg::RST_FLASH_CFG | (flash_cfg & keep_flash);
            wdog_ctrl <= srb_pkg::RST_WDOG_CTRL | (wdog_ctrl & keep_wdog);
        end
        else if (wr_en && !in_reset)
        begin
            if (sel_xint)
                xint_en <= pwdata[7:0];
            if (sel_pwr)
                pwr_ctrl <= pwdata[7:0];
            if (sel_flash)
                flash_cfg <= pwdata[7:0];
            if (sel_wdog)
                wdog_ctrl <= pwdata[7:0];
        end
    end

    // Sticky events: a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_sts <= '0;
            irq_en  <= '0;
        end
        else
        begin
            irq_sts <= (irq_sts & ~((wr_en && sel_clr) ? pwdata[srb_pkg::EV_NUM-1:0] : '0)) | ev;
            if (wr_en && sel_en)
                irq_en <= pwdata[srb_pkg::EV_NUM-1:0];
        end
    end

    // APB slave: zero wait states, error on unmapped address
    wire [31:0] rd_mux = sel_xint  ? {24'h000000, xint_en} :
                         sel_pwr   ? {24'h000000, pwr_ctrl} :
                         sel_flash ? {24'h000000, flash_cfg} :
                         sel_wdog  ? {24'h000000, wdog_ctrl} :
                         sel_stat ? {28'h0000000, bod_ok, pin_ok, powered, in_reset} :
                         sel_sts  ? {28'h0000000, irq_sts} :
                         sel_en   ? {28'h0000000, irq_en} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Outputs to the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset     <= 1'b1;
            fetch_vector   <= srb_pkg::RESET_VECTOR;
            vector_load    <= 1'b0;
            strobe_weak_hi <= 1'b1;
            port_weak_hi   <= 1'b1;
            ram_init_skip  <= 1'b0;
            bod_irq_req    <= 1'b0;
            bod_irq_prio   <= srb_pkg::BOD_PRIORITY;
            irq            <= 1'b0;
        end
        else
        begin
            core_reset     <= (next_state != ST_RUN);
            // R3: strobes weak high during reset
            strobe_weak_hi <= (next_state != ST_RUN);
            // R6: ports pulled high during power-up sequence
            port_weak_hi   <= (next_state == ST_INIT) || (next_state == ST_HOLD) || (state == ST_INIT);
            // R4: RAM not touched after first power-up
            ram_init_skip  <= powered;
            // R1: restart at 0000H; R12: brown-out vector 004BH
            vector_load    <= (state == ST_REL) || (state == ST_RUN && bod_ok && bod_ie && !power_down && !bod_irq_req);
            fetch_vector   <= (state == ST_REL) ? srb_pkg::RESET_VECTOR : srb_pkg::BOD_VECTOR;
            // R15: no request while powered down
            bod_irq_req    <= (state == ST_RUN) && bod_ok && bod_ie && !power_down;
            bod_irq_prio   <= srb_pkg::BOD_PRIORITY;
            irq            <= |(irq_sts & irq_en);
        end
    end

    // R10: no brown-out action before four low clocks
    a_bod_filter_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bod_ok) |-> $past(brownout_low, 1) && $past(brownout_low, 2)
            && $past(brownout_low, 3) && $past(brownout_low, 4)) // R10
        else $error("brown-out qualified too early");
    // R14: pin reset only if the synchronised pin sample 24 clocks earlier was high
    a_pin_qualify: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pin_ok) |-> $past(pin_s2, 24) == 1'b1) // R14
        else $error("reset pin qualified too early");
    // R11: disabled brown-out forces reset next cycle
    a_bod_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (bod_ok && !bod_ie && state == ST_RUN) |=> (state == ST_HOLD) ##1 core_reset) // R11
        else $error("brown-out did not reset");
    // R12: enabled brown-out gives interrupt not reset
    a_bod_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (bod_ok && bod_ie && state == ST_RUN && !power_down && !sys_rst) |=> bod_irq_req && state == ST_RUN) // R12
        else $error("brown-out interrupt missing");
    // R13: enable dropped during brown-out resets
    a_bod_ie_drop: assert property (@(posedge pclk) disable iff (!presetn)
        bod_ie_fall |=> state == ST_HOLD) // R13
        else $error("enable drop did not reset");
    // R8: software reset only from a rising bit
    a_sw_rst_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_RUN && !pin_rst && !bod_ok && $stable(flash_cfg[srb_pkg::BIT_SW_RST])) |=> state == ST_RUN) // R8
        else $error("spurious software reset");
    // R9: kept bits survive a software reset
    a_sw_rst_keep: assert property (@(posedge pclk) disable iff (!presetn)
        swr_edge |=> wdog_ctrl[srb_pkg::BIT_WDOG_STS] == $past(wdog_ctrl[srb_pkg::BIT_WDOG_STS])
            && flash_cfg[srb_pkg::BIT_SW_RST] && xint_en == srb_pkg::RST_XINT_EN) // R9
        else $error("kept bits lost on reset");
    // R1: release loads vector 0000H
    a_reset_vector: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_REL) |=> vector_load && fetch_vector == 16'h0000 && !core_reset) // R1
        else $error("wrong reset vector");
    // R3: strobes high whenever core reset held
    a_strobe_high: assert property (@(posedge pclk) disable iff (!presetn)
        (state != ST_RUN) |-> strobe_weak_hi) // R3
        else $error("strobes not high in reset");
    // R7: power-on flag cleared only by a write
    a_pwr_on_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pwr_ctrl[srb_pkg::BIT_PWR_ON]) |-> $past(wr_en && sel_pwr)) // R7
        else $error("power-on flag lost");
endmodule // srb_core

// file: testbench/srb_reset_source.sv
// Board reset circuit model that drives the reset pin
module srb_reset_source (
    input  wire logic pclk,      // Clock
    output logic      reset_pin  // Pin level, idle low through pull-down
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle low, as the pull-down resistor leaves it
    initial reset_pin = 1'b0;

    task automatic press(input int n);
        @(posedge pclk);
        reset_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        reset_pin <= 1'b0;
    endtask
endmodule // srb_reset_source

// file: testbench/tb_system_reset_brownout.sv
// Self-checking bench for the reset and brown-out block
module tb_system_reset_brownout;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk         = 1'b0;
    logic        presetn      = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [7:0]  paddr        = 8'h00;
    logic [31:0] pwdata       = 32'h0;
    logic        brownout_low = 1'b0;
    logic        power_down   = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready, pslverr, reset_pin, core_reset, vector_load, strobe_weak_hi;
    logic        port_weak_hi, ram_init_skip, bod_irq_req, irq, rerr;
    logic [15:0] fetch_vector;
    logic [15:0] last_vec     = 16'hffff;
    logic [3:0]  bod_irq_prio;
    logic        cr_q         = 1'b0;
    int          fails        = 0;
    int          check_count  = 0;
    int          rst_cnt      = 0;
    int          r0;

    always #20 pclk = ~pclk;

    srb_core srb_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin(reset_pin), .brownout_low(brownout_low),
        .power_down(power_down), .core_reset(core_reset), .fetch_vector(fetch_vector),
        .vector_load(vector_load), .strobe_weak_hi(strobe_weak_hi), .port_weak_hi(port_weak_hi),
        .ram_init_skip(ram_init_skip), .bod_irq_req(bod_irq_req), .bod_irq_prio(bod_irq_prio),
        .irq(irq));

    srb_reset_source srb_reset_source_inst (.pclk(pclk), .reset_pin(reset_pin));

    // Count reset entries and keep the last loaded vector; mid-cycle, where outputs are settled
    always @(negedge pclk)
    begin
        cr_q <= core_reset;
        if (core_reset === 1'b1 && cr_q !== 1'b1) rst_cnt <= rst_cnt + 1;
        if (vector_load === 1'b1) last_vec <= fetch_vector;
    end

    task automatic test_done;
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) fails++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    // Bounded wait for the core reset level, polled mid-cycle, then back on a rising edge
    task automatic wait_cr(input logic v);
        int n;
        n = 0;
        while (core_reset !== v && n < 200)
        begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, core_reset}, {31'h0, v});
        @(posedge pclk);
    endtask

    task automatic dip(input int n);
        @(posedge pclk);
        brownout_low <= 1'b1;
        repeat (n) @(posedge pclk);
        brownout_low <= 1'b0;
    endtask

    // Watchdog: whole sequence needs well under 5000 clocks
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({30'h0, port_weak_hi, strobe_weak_hi}, 32'h3);
        wait_cr(1'b0);
        chk({16'h0, last_vec}, 32'h0);
        chk({28'h0, bod_irq_prio}, 32'h2);
        rd(srb_pkg::OFF_PWR_CTRL, 32'h10);
        chk({31'h0, ram_init_skip}, 32'h1);
        rd(srb_pkg::OFF_XINT_EN, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, srb_pkg::OFF_XINT_EN, 32'h8);
        apb(1'b1, srb_pkg::OFF_WDOG_CTRL, 32'h4);
        r0 = rst_cnt;
        srb_reset_source_inst.press(20);
        repeat (40) @(posedge pclk);
        chk(32'(rst_cnt), 32'(r0));
        srb_reset_source_inst.press(24);
        wait_cr(1'b1);
        chk({31'h0, strobe_weak_hi}, 32'h1);
        wait_cr(1'b0);
        rd(srb_pkg::OFF_XINT_EN, 32'h0);
        rd(srb_pkg::OFF_WDOG_CTRL, 32'h0);
        rd(srb_pkg::OFF_PWR_CTRL, 32'h10);
        rd(srb_pkg::OFF_IRQ_STS, 32'h1);
        apb(1'b1, srb_pkg::OFF_PWR_CTRL, 32'h0);
        rd(srb_pkg::OFF_PWR_CTRL, 32'h0);
        apb(1'b1, srb_pkg::OFF_IRQ_CLR, 32'hf);
        rd(srb_pkg::OFF_IRQ_STS, 32'h0);
        rd(srb_pkg::OFF_IRQ_CLR, 32'h0);
        // Software reset keeps its own bit and the watchdog status
        apb(1'b1, srb_pkg::OFF_XINT_EN, 32'h8);
        apb(1'b1, srb_pkg::OFF_WDOG_CTRL, 32'h4);
        last_vec <= 16'hffff;
        apb(1'b1, srb_pkg::OFF_FLASH_CFG, 32'h2);
        wait_cr(1'b1);
        wait_cr(1'b0);
        chk({16'h0, last_vec}, 32'h0);
        rd(srb_pkg::OFF_FLASH_CFG, 32'h2);
        rd(srb_pkg::OFF_WDOG_CTRL, 32'h4);
        rd(srb_pkg::OFF_XINT_EN, 32'h0);
        // Interrupt raised, masked, cleared
        apb(1'b1, srb_pkg::OFF_IRQ_EN, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, srb_pkg::OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, srb_pkg::OFF_IRQ_EN, 32'h2);
        apb(1'b1, srb_pkg::OFF_IRQ_CLR, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Rewriting one, then a real zero-to-one edge
        r0 = rst_cnt;
        apb(1'b1, srb_pkg::OFF_FLASH_CFG, 32'h2);
        repeat (40) @(posedge pclk);
        chk(32'(rst_cnt), 32'(r0));
        apb(1'b1, srb_pkg::OFF_FLASH_CFG, 32'h0);
        apb(1'b1, srb_pkg::OFF_FLASH_CFG, 32'h2);
        wait_cr(1'b1);
        wait_cr(1'b0);
        // Brown-out: short dip ignored, long one resets
        r0 = rst_cnt;
        dip(3);
        repeat (40) @(posedge pclk);
        chk(32'(rst_cnt), 32'(r0));
        last_vec <= 16'hffff;
        dip(4);
        wait_cr(1'b1);
        wait_cr(1'b0);
        chk({16'h0, last_vec}, 32'h0);
        // Enabled brown-out vectors instead; clearing enable mid-event resets
        apb(1'b1, srb_pkg::OFF_XINT_EN, 32'h8);
        last_vec <= 16'hffff;
        brownout_low <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({31'h0, bod_irq_req}, 32'h1);
        chk({16'h0, last_vec}, 32'h4b);
        chk({31'h0, core_reset}, 32'h0);
        apb(1'b1, srb_pkg::OFF_XINT_EN, 32'h0);
        wait_cr(1'b1);
        brownout_low <= 1'b0;
        wait_cr(1'b0);
        // No brown-out request while powered down; looked at while the dip still stands
        apb(1'b1, srb_pkg::OFF_XINT_EN, 32'h8);
        power_down <= 1'b1;
        brownout_low <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({31'h0, bod_irq_req}, 32'h0);
        brownout_low <= 1'b0;
        test_done();
    end
endmodule // tb_system_reset_brownout
